/* File: hdl/ufb_top.sv */
// receive address filter and dedicated baud generator of the second serial channel
// Functional notes
// [R1] filter on in 9-bit mode: flag only when received ninth bit is 1
// [R2] address bytes carry ninth bit 1, data bytes carry ninth bit 0
// [R3] addressed slave clears filter enable, sets it again after the message
// [R4] filter on in 8-bit mode: flag only with a high stop bit
// [R5] legacy generator: free 8-bit timer at half clock, reload on overflow
// [R6] timer starts only after software writes the low reload register
// [R7] legacy bit rate is clock over 32 times (256 minus reload)
// [R8] new generator: free 10-bit timer at half clock, low 8 bits reloaded
// [R9] upper two timer bits reload from bits 0 and 1 of high register
// [R10] writing low reload register reloads the 10-bit timer at once
// [R11] new bit rate is clock over 32 times (1024 minus reload)
// [R12] reset: low reload zero, two used high bits read as ones
// [R13] format select 0 gives 9-bit frames, 1 gives 8-bit frames
// [R14] final shift loads data, ninth bit, flag only if flag clear and filter passes
// [R15] flag set mid stop bit, stays set until software clears it
`include "ufb_regs.svh"
`default_nettype none
module ufb_top #(
    parameter bit LEGACY_GEN = 1'b0
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata_q,
    input  wire logic       rxd,
    output logic            rx_out_valid,
    output logic      [8:0] rx_out_data,
    input  wire logic       rx_out_ready
);
    logic [7:0] rld_lo_q;
    logic [1:0] rld_hi_q;
    logic [9:0] tmr_q;
    logic       running_q;
    logic       half_q;
    logic       ovf;
    logic [9:0] reload_val;
    logic [9:0] reload_new;
    logic       wr_ctrl, wr_lo, wr_hi;
    logic       mode_q, filt_q, ren_q, tb8_q, ti_q, ri_q, rx_ninth_q;
    logic [7:0] rx_data_q;
    ufb_pkg::ufb_rx_state_type st_q;
    logic [3:0] div_q;
    logic [3:0] bit_q;
    logic [1:0] vote_q;
    logic [8:0] sh_q;
    logic       rxd_prev_q;
    logic       vote;
    logic       decide;
    logic       final_bit;
    logic       nin;
    logic [7:0] dat;
    logic       load;
    logic       buf_ready;
    logic       sw_clr_ri;

    function automatic logic majority(input logic a, input logic b, input logic c);
        majority = (a & b) | (a & c) | (b & c);
    endfunction

    assign wr_ctrl = sfr_wr && (sfr_addr == `UFB_ADDR_CTRL);
    assign wr_lo   = sfr_wr && (sfr_addr == `UFB_ADDR_RLD_LO);
    assign wr_hi   = sfr_wr && (sfr_addr == `UFB_ADDR_RLD_HI);
    assign sw_clr_ri = wr_ctrl && !sfr_wdata[`UFB_CTRL_RI];

    // legacy timer is the 10-bit one with its top bits pinned, so 1024-(768+r) = 256-r
    assign reload_val = LEGACY_GEN ? {`UFB_LEGACY_UPPER, rld_lo_q} : {rld_hi_q, rld_lo_q}; // [R9]
    assign reload_new = LEGACY_GEN ? {`UFB_LEGACY_UPPER, sfr_wdata} : {rld_hi_q, sfr_wdata};
    assign ovf = running_q && half_q && (tmr_q == `UFB_TMR_MAX); // [R5] [R8]

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rld_lo_q <= `UFB_RLD_LO_RST; // [R12]
            rld_hi_q <= `UFB_RLD_HI_RST; // [R12]
        end else begin
            if (wr_lo) begin
                rld_lo_q <= sfr_wdata;
            end
            if (wr_hi) begin
                rld_hi_q <= sfr_wdata[1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tmr_q     <= '0;
            running_q <= 1'b0;
            half_q    <= 1'b0;
        end else begin
            half_q <= ~half_q;
            if (wr_lo) begin
                tmr_q     <= reload_new; // [R10]
                running_q <= 1'b1; // [R6]
                half_q    <= 1'b0;
            end else if (running_q && half_q) begin
                // one overflow per sixteenth of a bit: rate = clk / (32 * (N - reload))
                tmr_q <= (tmr_q == `UFB_TMR_MAX) ? reload_val : tmr_q + 10'h001; // [R7] [R11]
            end
        end
    end

    // sample point decision
    assign vote      = majority(vote_q[1], vote_q[0], rxd);
    assign decide    = (st_q == ufb_pkg::UFB_RECV) && ovf && (div_q == `UFB_SMP_LAST);
    assign final_bit = mode_q ? (bit_q == `UFB_IDX_NINTH) : (bit_q == `UFB_IDX_STOP_A); // [R13]
    assign nin       = mode_q ? vote : sh_q[8];
    assign dat       = mode_q ? sh_q[8:1] : sh_q[7:0];
    // a full buffer is treated like a pending flag: the frame is dropped, not overwritten
    assign load      = decide && final_bit && !ri_q && buf_ready // [R14]
                       && (!filt_q || nin); // [R1] [R2] [R4]

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q       <= ufb_pkg::UFB_IDLE;
            div_q      <= '0;
            bit_q      <= '0;
            vote_q     <= '0;
            sh_q       <= '0;
            rxd_prev_q <= 1'b1;
        end else if (ovf) begin
            rxd_prev_q <= rxd;
            unique case (st_q)
                ufb_pkg::UFB_IDLE: begin
                    if (ren_q && rxd_prev_q && !rxd) begin
                        st_q  <= ufb_pkg::UFB_RECV;
                        div_q <= '0;
                        bit_q <= `UFB_IDX_START;
                        sh_q  <= '1;
                    end
                end
                ufb_pkg::UFB_RECV: begin
                    div_q <= div_q + 4'h1;
                    if (div_q == `UFB_SMP_FIRST || div_q == `UFB_SMP_SECOND) begin
                        vote_q <= {vote_q[0], rxd};
                    end
                    if (decide) begin
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == `UFB_IDX_START && vote) begin
                            st_q <= ufb_pkg::UFB_IDLE;
                        end else if (final_bit) begin
                            st_q <= ufb_pkg::UFB_IDLE;
                        end else if (bit_q != `UFB_IDX_START) begin
                            sh_q <= {vote, sh_q[8:1]};
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= 1'b0;
            filt_q <= 1'b0;
            ren_q  <= 1'b0;
            tb8_q  <= 1'b0;
            ti_q   <= 1'b0;
        end else if (wr_ctrl) begin
            mode_q <= sfr_wdata[`UFB_CTRL_MODE];
            filt_q <= sfr_wdata[`UFB_CTRL_FILT];
            ren_q  <= sfr_wdata[`UFB_CTRL_REN];
            tb8_q  <= sfr_wdata[`UFB_CTRL_TB8];
            ti_q   <= sfr_wdata[`UFB_CTRL_TI];
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ri_q       <= 1'b0;
            rx_ninth_q <= 1'b0;
            rx_data_q  <= '0;
        end else if (load) begin
            ri_q       <= 1'b1; // [R15]
            rx_ninth_q <= nin; // [R14]
            rx_data_q  <= dat;
        end else if (wr_ctrl) begin
            ri_q       <= sfr_wdata[`UFB_CTRL_RI];
            rx_ninth_q <= sfr_wdata[`UFB_CTRL_RB8];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata_q <= '0;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                `UFB_ADDR_CTRL:   sfr_rdata_q <= {mode_q, 1'b0, filt_q, ren_q, tb8_q,
                                                  rx_ninth_q, ti_q, ri_q};
                `UFB_ADDR_DATA:   sfr_rdata_q <= rx_data_q;
                `UFB_ADDR_RLD_LO: sfr_rdata_q <= rld_lo_q;
                `UFB_ADDR_RLD_HI: sfr_rdata_q <= {6'h00, rld_hi_q};
                default:          sfr_rdata_q <= '0;
            endcase
        end else begin
            sfr_rdata_q <= '0;
        end
    end

    ufb_skid_buf #(.W(9)) u_buf (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (load),
        .in_data   ({nin, dat}),
        .in_ready  (buf_ready),
        .out_valid (rx_out_valid),
        .out_data  (rx_out_data),
        .out_ready (rx_out_ready)
    );

    // helper state for the checks
    logic        lo_seen_q, hi_seen_q, gap_ok_q;
    logic [11:0] gap_q;
    logic [7:0]  frm_ticks_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lo_seen_q   <= 1'b0;
            hi_seen_q   <= 1'b0;
            gap_q       <= '0;
            gap_ok_q    <= 1'b0;
            frm_ticks_q <= '0;
        end else begin
            lo_seen_q <= lo_seen_q | wr_lo;
            hi_seen_q <= hi_seen_q | wr_hi;
            // ticks since the start edge, counted apart from the bit counters
            frm_ticks_q <= (ovf && st_q == ufb_pkg::UFB_IDLE) ? 8'h00 : frm_ticks_q + {7'h00, ovf};
            gap_q     <= (ovf || wr_lo) ? 12'h000 : gap_q + 12'h001;
            gap_ok_q  <= (wr_lo || wr_hi) ? 1'b0 : (ovf ? 1'b1 : gap_ok_q);
        end
    end

    AST_FILT_NINTH: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
        $rose(ri_q) && !$past(wr_ctrl) && !mode_q && filt_q |-> rx_ninth_q)
        else $error("9-bit frame flagged with ninth bit low");
    AST_FILT_STOP: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4]
        $rose(ri_q) && !$past(wr_ctrl) && mode_q && filt_q |-> rx_ninth_q)
        else $error("8-bit frame flagged without valid stop bit");
    AST_NO_START: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
        !lo_seen_q |-> !running_q && !ovf)
        else $error("baud timer ran before low reload write");
    AST_WR_RELOAD: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
        wr_lo && !LEGACY_GEN |=> tmr_q == {rld_hi_q, $past(sfr_wdata)} && running_q)
        else $error("low reload write did not reload timer");
    AST_OVF_RELOAD: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
        ovf && !wr_lo && !wr_hi |=> tmr_q == reload_val)
        else $error("overflow reload value wrong");
    AST_RESET_VAL: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
        (!lo_seen_q |-> rld_lo_q == `UFB_RLD_LO_RST) and
        (!hi_seen_q |-> rld_hi_q == `UFB_RLD_HI_RST))
        else $error("reload register reset value wrong");
    AST_TICK_GAP: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7] [R11]
        ovf && gap_ok_q && !wr_hi |-> gap_q == 12'({2'b00, ~reload_val, 1'b1}))
        else $error("baud tick spacing wrong");
    AST_RI_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R15]
        ri_q && !sw_clr_ri |=> ri_q)
        else $error("receive flag dropped without software clear");
    AST_NO_OVERRUN: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
        ri_q && !sw_clr_ri |=> $stable(rx_data_q))
        else $error("receive data overwritten while flag set");
    AST_FORMAT: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R13]
        load |-> frm_ticks_q == (mode_q ? `UFB_TICKS_EIGHT : `UFB_TICKS_NINE))
        else $error("frame ended at wrong bit");

    COV_LOAD_A: cover property (@(posedge ref_clk) disable iff (!rst_n) load && !mode_q);
    COV_LOAD_B: cover property (@(posedge ref_clk) disable iff (!rst_n) load && mode_q);
    COV_FILTERED: cover property (@(posedge ref_clk) disable iff (!rst_n)
        decide && final_bit && filt_q && !nin);
    COV_BUF_FULL: cover property (@(posedge ref_clk) disable iff (!rst_n) !buf_ready);
endmodule
`default_nettype wire

/* File: hdl/ufb_regs.svh */
// register addresses, field positions, reset values and counts of the serial channel
`ifndef UFB_REGS_SVH
`define UFB_REGS_SVH
`define UFB_ADDR_CTRL     8'h9b
`define UFB_ADDR_DATA     8'h9c
`define UFB_ADDR_RLD_LO   8'h9d
`define UFB_ADDR_RLD_HI   8'hbb
`define UFB_CTRL_RI       0
`define UFB_CTRL_TI       1
`define UFB_CTRL_RB8      2
`define UFB_CTRL_TB8      3
`define UFB_CTRL_REN      4
`define UFB_CTRL_FILT     5
`define UFB_CTRL_MODE     7
`define UFB_RLD_LO_RST    8'h00
`define UFB_RLD_HI_RST    2'h3
`define UFB_LEGACY_UPPER  2'h3
`define UFB_TMR_MAX       10'h3ff
`define UFB_SMP_FIRST     4'h6
`define UFB_SMP_SECOND    4'h7
`define UFB_SMP_LAST      4'h8
`define UFB_IDX_START     4'h0
`define UFB_IDX_NINTH     4'h9
`define UFB_IDX_STOP_A    4'ha
`define UFB_TICKS_NINE    8'ha8
`define UFB_TICKS_EIGHT   8'h98
`endif

/* File: hdl/ufb_pkg.sv */
// types used by the serial channel receive state machine
`default_nettype none
package ufb_pkg;
    typedef enum logic {UFB_IDLE, UFB_RECV} ufb_rx_state_type;
endpackage
`default_nettype wire

/* File: hdl/ufb_skid_buf.sv */
// two-entry buffer with valid and ready on both sides
`default_nettype none
module ufb_skid_buf #(
    parameter int W = 9
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    logic [W-1:0] slot_q [0:1];
    logic         v1_q;
    logic         push;
    logic         pop;

    assign push = in_valid & in_ready;
    assign pop  = out_valid & out_ready;
    assign out_data = slot_q[0];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_q[0] <= '0;
            slot_q[1] <= '0;
            out_valid <= 1'b0;
            v1_q      <= 1'b0;
            in_ready  <= 1'b1;
        end else begin
            if (!out_valid) begin
                if (push) begin
                    slot_q[0] <= in_data;
                    out_valid <= 1'b1;
                end
            end else if (pop) begin
                if (v1_q) begin
                    slot_q[0] <= slot_q[1];
                    if (push) begin
                        slot_q[1] <= in_data;
                    end else begin
                        v1_q     <= 1'b0;
                        in_ready <= 1'b1;
                    end
                end else if (push) begin
                    slot_q[0] <= in_data;
                end else begin
                    out_valid <= 1'b0;
                end
            end else if (push) begin
                // full: ready drops so no push lands on a held word; the receiver drops its frame meanwhile
                slot_q[1] <= in_data;
                v1_q      <= 1'b1;
                in_ready  <= 1'b0;
            end
        end
    end

    AST_NO_OVERFILL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        v1_q && !pop |=> $stable(slot_q[1]))
        else $error("buffer overwrote a held word");
endmodule
`default_nettype wire

/* File: tb/ufb_line_peer.sv */
// remote node on the shared serial line, sending asynchronous frames
`default_nettype none
module ufb_line_peer (
    input  wire logic ref_clk,
    output logic      rxd_line
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle line rests at mark level
    initial rxd_line = 1'b1;
    // bt is the bit time in clocks; the line changes just after an edge only
    task automatic send(input logic [7:0] d, input logic nine, input logic b9,
                        input logic stp, input int bt);
        logic [10:0] f;
        int          n;
        f = nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
        n = nine ? 11 : 10;
        @(posedge ref_clk);
        #1;
        for (int i = 0; i < n; i++) begin
            rxd_line = f[i];
            repeat (bt) @(posedge ref_clk);
            #1;
        end
        rxd_line = 1'b1;
    endtask
endmodule
`default_nettype wire

/* File: tb/test_ufb_top.sv */
// self-checking bench for the receive filter and baud generator
`include "ufb_regs.svh"
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
    $display("FAIL t=%0t got %h exp %h", $time, a, e); end end
module test_ufb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] CTRL = `UFB_ADDR_CTRL;
    logic       ref_clk      = 1'b0;
    logic       rst_n        = 1'b0;
    logic [7:0] sfr_addr     = 8'h00;
    logic [7:0] sfr_wdata    = 8'h00;
    logic       sfr_wr       = 1'b0;
    logic       sfr_rd       = 1'b0;
    logic [7:0] sfr_rdata_q;
    logic       rxd;
    logic       rx_out_valid;
    logic [8:0] rx_out_data;
    logic       rx_out_ready = 1'b0;
    logic       stall        = 1'b0;
    logic       rd_last      = 1'b0;
    int         failures     = 0;
    int         checks_done  = 0;
    int         seed         = 32'h63d6;
    logic [7:0] exp_rd[$];
    logic [8:0] exp_rx[$];
    logic [7:0] exp_rd_now;
    logic [8:0] exp_rx_now;
    logic [7:0] last_d       = 8'h00;
    logic [7:0] lg_rdata_q;
    logic       lg_out_valid;
    logic [8:0] lg_out_data;

    ufb_top #(.LEGACY_GEN(1'b0)) u_ufb_top (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .sfr_addr    (sfr_addr),
        .sfr_wdata   (sfr_wdata),
        .sfr_wr      (sfr_wr),
        .sfr_rd      (sfr_rd),
        .sfr_rdata_q (sfr_rdata_q),
        .rxd         (rxd),
        .rx_out_valid(rx_out_valid),
        .rx_out_data (rx_out_data),
        .rx_out_ready(rx_out_ready)
    );
    ufb_line_peer u_ufb_line_peer (
        .ref_clk (ref_clk),
        .rxd_line(rxd)
    );
    // legacy generator on the same stimulus: high reload stays 3 at every low write,
    // so its rates and results must equal the expectations of the 10-bit one
    ufb_top #(.LEGACY_GEN(1'b1)) u_ufb_top_legacy (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .sfr_addr    (sfr_addr),
        .sfr_wdata   (sfr_wdata),
        .sfr_wr      (sfr_wr),
        .sfr_rd      (sfr_rd),
        .sfr_rdata_q (lg_rdata_q),
        .rxd         (rxd),
        .rx_out_valid(lg_out_valid),
        .rx_out_data (lg_out_data),
        .rx_out_ready(rx_out_ready)
    );

    always #5 ref_clk = ~ref_clk;

    // random consumer stalls, so the buffer sees back pressure all through
    always @(posedge ref_clk) begin
        #1;
        rx_out_ready = !stall && ($random(seed) % 4 != 0);
    end

    // read data stands one cycle after the strobe; words are taken when popped
    always @(posedge ref_clk) begin
        if (rd_last) begin
            exp_rd_now = exp_rd.pop_front();
            `CHK(sfr_rdata_q, exp_rd_now)
            `CHK(lg_rdata_q, exp_rd_now)
        end
        if (rx_out_valid === 1'b1 && rx_out_ready) begin
            `CHK(exp_rx.size() != 0, 1'b1)
            if (exp_rx.size() != 0) begin
                exp_rx_now = exp_rx.pop_front();
                `CHK(rx_out_data, exp_rx_now)
                `CHK({lg_out_valid, lg_out_data}, {1'b1, exp_rx_now})
            end
        end
        rd_last <= sfr_rd;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        #1;
        sfr_addr = a;
        sfr_rd = 1'b1;
        exp_rd.push_back(e);
        @(posedge ref_clk);
        #1;
        sfr_rd = 1'b0;
    endtask

    // keep says whether the device must take the frame
    task automatic frame(input logic nine, input logic b9, input logic stp, input int bt,
                         input logic keep);
        logic [7:0] d;
        d = 8'($random(seed));
        last_d = d;
        if (keep) begin
            exp_rx.push_back(nine ? {b9, d} : {stp, d});
        end
        u_ufb_line_peer.send(d, nine, b9, stp, bt);
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic drain(input string name);
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 2000 && exp_rx.size() != 0; i++) begin
            @(posedge ref_clk);
        end
        `CHK(exp_rx.size(), 0)
        $display("test %s done", name);
    endtask

    task automatic give_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #400000;
        failures++;
        $display("watchdog expired");
        give_verdict();
    end

    initial begin
        logic b;
        repeat (2) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        rd(CTRL, 8'h00);
        rd(`UFB_ADDR_RLD_LO, 8'h00);
        rd(`UFB_ADDR_RLD_HI, 8'h03);
        wr(`UFB_ADDR_RLD_HI, 8'hfe);
        rd(`UFB_ADDR_RLD_HI, 8'h02);
        wr(8'h80, 8'h5a);
        rd(8'h80, 8'h00);
        drain("reset values");
        // no low reload written yet, so no sample ticks and no frame
        wr(CTRL, 8'h10);
        frame(1'b1, 1'b1, 1'b1, 32, 1'b0);
        rd(CTRL, 8'h10);
        drain("timer stopped");
        // reload 0x3ff: tick every 2 clocks, bit time 32 clocks
        wr(`UFB_ADDR_RLD_HI, 8'h07);
        wr(`UFB_ADDR_RLD_LO, 8'hff);
        rd(`UFB_ADDR_RLD_LO, 8'hff);
        for (int i = 0; i < 4; i++) begin
            b = 1'($random(seed));
            frame(1'b1, b, 1'b1, 32, 1'b1);
            rd(CTRL, 8'h11 | {5'h00, b, 2'b00});
            rd(`UFB_ADDR_DATA, last_d);
            wr(CTRL, 8'h10);
        end
        drain("nine bit plain");
        wr(CTRL, 8'h30);
        frame(1'b1, 1'b0, 1'b1, 32, 1'b0);
        rd(CTRL, 8'h30);
        frame(1'b1, 1'b1, 1'b1, 32, 1'b1);
        rd(CTRL, 8'h35);
        frame(1'b1, 1'b1, 1'b1, 32, 1'b0);
        rd(CTRL, 8'h35);
        wr(CTRL, 8'h10);
        frame(1'b1, 1'b0, 1'b1, 32, 1'b1);
        rd(CTRL, 8'h11);
        wr(CTRL, 8'h30);
        frame(1'b1, 1'b0, 1'b1, 32, 1'b0);
        drain("nine bit filter");
        wr(CTRL, 8'hb0);
        frame(1'b0, 1'b0, 1'b0, 32, 1'b0);
        rd(CTRL, 8'hb0);
        frame(1'b0, 1'b0, 1'b1, 32, 1'b1);
        rd(CTRL, 8'hb5);
        wr(CTRL, 8'h90);
        frame(1'b0, 1'b0, 1'b0, 32, 1'b1);
        rd(CTRL, 8'h91);
        drain("eight bit");
        // reload 0x3fc: bit time 32 * 4 = 128 clocks
        wr(CTRL, 8'h10);
        wr(`UFB_ADDR_RLD_LO, 8'hfc);
        frame(1'b1, 1'b1, 1'b1, 128, 1'b1);
        rd(CTRL, 8'h15);
        drain("slow rate");
        wr(CTRL, 8'h10);
        wr(`UFB_ADDR_RLD_LO, 8'hff);
        stall = 1'b1;
        frame(1'b1, 1'b0, 1'b1, 32, 1'b1);
        wr(CTRL, 8'h10);
        frame(1'b1, 1'b0, 1'b1, 32, 1'b1);
        wr(CTRL, 8'h10);
        frame(1'b1, 1'b1, 1'b1, 32, 1'b0);
        rd(CTRL, 8'h10);
        stall = 1'b0;
        drain("buffer full");
        give_verdict();
    end
endmodule
`default_nettype wire
